// ### design/msr_bank.sv
// serial special-register bank of a motor drive: frame engine, check sum, registers and outputs
`timescale 1ns/1ps
`include "msr_defs.svh"

// Notes on behaviour
// - running frequency readable at RUNNING_FREQUENCY, read-only
// - bus and output voltage at DC_BUS_VOLTAGE/OUTPUT_VOLTAGE
// - output torque readable at OUTPUT_TORQUE
// - three analog input voltages at ANALOG_IN_ONE_VOLTAGE..ANALOG_IN_THREE_VOLTAGE
// - encoder feedback frequency readable at ENCODER_FEEDBACK_FREQUENCY
// - input terminals INPUT_TERMINAL_STATE, output terminals OUTPUT_TERMINAL_STATE
// - 2001H drives terminals whose function is 20
// - bit 2 drives the first relay
// - bit 4 drives frequency terminal; 1,3 unused
// - ANALOG_OUT_ONE_LEVEL sets analog out one, 0..7FFF
// - ANALOG_OUT_TWO_LEVEL sets analog out two, 0..7FFF
// - 2004H sets pulse output, 0..7FFF
// - 3000H reads 1 forward, 2 reverse, 3 stop
// - 8000H reads fault code, zero without fault
// - 2000H takes command codes one to seven
// - commands act only when source selects communication
// - two-byte CRC appended and checked on frames
// - CRC preset all ones, data bits only
// - xor byte, eight shifts, polynomial A001
// - CRC sent low byte before high byte
// - bad CRC answered with exception code 3
// - frames bounded by 3.5 characters of silence
module msr_bank
  import msr_pkg::*;
#(
  parameter logic [23:0] SILENCE_CYCLES = 24'(`MSR_SILENCE_CYCLES),
  parameter logic [23:0] TX_GAP_CYCLES = 24'(`MSR_SILENCE_CYCLES + `MSR_CHAR_CYCLES)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] slave_address,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [15:0] mon_running_frequency,
  input wire logic [15:0] mon_dc_bus_voltage,
  input wire logic [15:0] mon_output_voltage,
  input wire logic [15:0] mon_output_current,
  input wire logic [15:0] mon_output_power,
  input wire logic [15:0] mon_output_torque,
  input wire logic [15:0] mon_running_speed,
  input wire logic [15:0] mon_input_terminal_state,
  input wire logic [15:0] mon_analog_in_one,
  input wire logic [15:0] mon_analog_in_two,
  input wire logic [15:0] mon_analog_in_three,
  input wire logic [15:0] mon_load_speed,
  input wire logic [15:0] mon_feedback_frequency,
  input wire logic [15:0] mon_encoder_frequency,
  input wire logic fault_active,
  input wire logic [15:0] fault_code,
  input wire logic [3:0] run_command_source,
  input wire logic [4:0] transistor_output_func,
  input wire logic [4:0] relay_one_func,
  input wire logic [4:0] freq_pulse_func,
  input wire logic [4:0] analog_out_one_func,
  input wire logic [4:0] analog_out_two_func,
  input wire logic [4:0] pulse_output_func,
  input wire logic drive_transistor,
  input wire logic drive_relay_one,
  input wire logic drive_freq_pulse,
  input wire logic [14:0] drive_analog_one,
  input wire logic [14:0] drive_analog_two,
  input wire logic [14:0] drive_pulse,
  output logic transistor_output,
  output logic relay_one_output,
  output logic freq_pulse_terminal,
  output logic [14:0] analog_out_one,
  output logic [14:0] analog_out_two,
  output logic [14:0] pulse_output,
  output logic [2:0] run_command,
  output logic run_command_strobe,
  output logic [15:0] run_state
);

  // ----------------------------------------------------------------
  // reset release and state
  // ----------------------------------------------------------------
  logic [1:0] rst_q; // reset release chain
  logic rst_n_sync; // released reset copy
  msr_state_s r; // registered state
  msr_state_s n; // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // one byte through the check sum, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      if (v[0]) begin
        v = (v >> 1) ^ `MSR_CRC_POLY;
      end else begin
        v = v >> 1;
      end
    end
    return v;
  endfunction

  // clamp a written level to full scale
  function automatic logic [14:0] clamp_level(input logic [15:0] v);
    return v[15] ? `MSR_FULL_SCALE : v[14:0];
  endfunction

  // readable words: bit 16 says mapped, low 16 bits the value
  function automatic logic [16:0] rd_word(input logic [15:0] a);
    logic [16:0] w;
    w = 17'h00000;
    unique case (a)
      `MSR_ADDR_RUN_FREQ: w = {1'b1, mon_running_frequency};
      `MSR_ADDR_DC_BUS: w = {1'b1, mon_dc_bus_voltage};
      `MSR_ADDR_OUT_VOLT: w = {1'b1, mon_output_voltage};
      `MSR_ADDR_OUT_CURR: w = {1'b1, mon_output_current};
      `MSR_ADDR_OUT_POWER: w = {1'b1, mon_output_power};
      `MSR_ADDR_OUT_TORQUE: w = {1'b1, mon_output_torque};
      `MSR_ADDR_RUN_SPEED: w = {1'b1, mon_running_speed};
      `MSR_ADDR_IN_TERM: w = {1'b1, mon_input_terminal_state};
      `MSR_ADDR_OUT_TERM: begin
        // live terminal levels as driven by this block
        w = 17'h10000;
        w[`MSR_BIT_TRANSISTOR] = r.transistor_output;
        w[`MSR_BIT_RELAY] = r.relay_one_output;
        w[`MSR_BIT_FREQ] = r.freq_pulse_terminal;
      end
      `MSR_ADDR_AIN_ONE: w = {1'b1, mon_analog_in_one};
      `MSR_ADDR_AIN_TWO: w = {1'b1, mon_analog_in_two};
      `MSR_ADDR_AIN_THREE: w = {1'b1, mon_analog_in_three};
      `MSR_ADDR_LOAD_SPEED: w = {1'b1, mon_load_speed};
      `MSR_ADDR_FB_FREQ: w = {1'b1, mon_feedback_frequency};
      `MSR_ADDR_ENC_FREQ: w = {1'b1, mon_encoder_frequency};
      `MSR_ADDR_RUN_STATE: w = {1'b1, r.run_state};
      `MSR_ADDR_FAULT: w = {1'b1, fault_active ? fault_code : 16'h0000};
      default: w = 17'h00000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // reset release: two flops, asynchronous assert
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_q[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] func; // request function code
    logic [15:0] addr; // request word address
    logic [15:0] val; // request data or count
    logic [7:0] exc; // exception code, zero when none
    logic [16:0] w; // read result
    logic [15:0] ra; // address of one read word
    logic [7:0] tb; // byte next handed to the transmitter
    func = r.rx_buf[1];
    addr = {r.rx_buf[2], r.rx_buf[3]};
    val = {r.rx_buf[4], r.rx_buf[5]};
    exc = 8'h00;
    w = 17'h00000;
    ra = 16'h0000;
    tb = 8'h00;
    n = r;
    n.cmd_strobe = 1'b0;

    unique case (r.state)
      // line must stay quiet before a frame may start
      MSR_GAP: begin
        if (rx_valid) begin
          n.gap_cnt = 24'h000000;
        end else if (r.gap_cnt >= (r.gap_long ? TX_GAP_CYCLES : SILENCE_CYCLES)) begin
          n.state = MSR_RX;
          n.rx_cnt = 4'h0;
          n.rx_over = 1'b0;
          n.rx_crc = `MSR_CRC_PRESET;
        end else begin
          n.gap_cnt = r.gap_cnt + 24'h000001;
        end
      end

      // collect bytes until the line falls silent
      MSR_RX: begin
        if (rx_valid) begin
          n.gap_cnt = 24'h000000;
          n.rx_crc = crc_step(r.rx_crc, rx_data);
          if (r.rx_cnt < `MSR_REQ_LEN) begin
            n.rx_buf[r.rx_cnt[2:0]] = rx_data;
            n.rx_cnt = r.rx_cnt + 4'h1;
          end else begin
            n.rx_over = 1'b1;
          end
        end else if (r.rx_cnt != 4'h0) begin
          if (r.gap_cnt >= SILENCE_CYCLES) begin
            n.state = MSR_EXEC;
          end else begin
            n.gap_cnt = r.gap_cnt + 24'h000001;
          end
        end
      end

      // decode the frame, act on it and build the answer
      MSR_EXEC: begin
        n.tx_idx = 5'h00;
        n.tx_valid = 1'b0;
        n.tx_crc = `MSR_CRC_PRESET;
        n.tx_buf[0] = slave_address;
        n.tx_buf[1] = func;
        if (r.rx_over || r.rx_cnt != `MSR_REQ_LEN || r.rx_buf[0] != slave_address) begin
          // not for us or malformed: drop silently
          n.state = MSR_RX;
          n.rx_cnt = 4'h0;
          n.rx_over = 1'b0;
          n.rx_crc = `MSR_CRC_PRESET;
        end else begin
          n.state = MSR_TX;
          if (r.rx_crc != 16'h0000) begin
            exc = `MSR_EXC_CRC;
          end else if (func == `MSR_FC_READ) begin
            if (val == 16'h0000 || val > `MSR_MAX_READ) begin
              exc = `MSR_EXC_RANGE;
            end else begin
              n.tx_buf[2] = {val[6:0], 1'b0};
              n.tx_len = `MSR_READ_HDR + {1'b0, val[2:0], 1'b0};
              for (int k = 0; k < 4; k++) begin
                ra = addr + 16'(k);
                w = rd_word(ra);
                if (16'(k) < val && !w[16]) begin
                  exc = `MSR_EXC_ADDR;
                end
                n.tx_buf[3 + 2 * k] = w[15:8];
                n.tx_buf[4 + 2 * k] = w[7:0];
              end
            end
          end else if (func == `MSR_FC_WRITE || func == `MSR_FC_WRITE_RAM) begin
            w = rd_word(addr);
            if (w[16]) begin
              exc = `MSR_EXC_RDONLY;
            end else if (addr < `MSR_ADDR_RUN_CMD || addr > `MSR_ADDR_PULSE) begin
              exc = `MSR_EXC_ADDR;
            end else if (addr == `MSR_ADDR_RUN_CMD && (val == 16'h0000 || val > `MSR_CMD_MAX)) begin
              exc = `MSR_EXC_RANGE;
            end else begin
              n.tx_len = `MSR_ECHO_LEN;
              for (int k = 2; k < 6; k++) begin
                n.tx_buf[k] = r.rx_buf[k];
              end
              unique case (addr)
                `MSR_ADDR_RUN_CMD: begin
                  if (run_command_source == `MSR_SRC_COMM) begin
                    n.cmd_code = val[2:0];
                    n.cmd_strobe = 1'b1;
                    unique case (val[2:0])
                      `MSR_CMD_FWD, `MSR_CMD_JOG_FWD: n.run_state = `MSR_STATE_FWD;
                      `MSR_CMD_REV, `MSR_CMD_JOG_REV: n.run_state = `MSR_STATE_REV;
                      `MSR_CMD_COAST, `MSR_CMD_DECEL: n.run_state = `MSR_STATE_STOP;
                      default: n.run_state = r.run_state; // fault reset keeps motion state
                    endcase
                  end
                end
                `MSR_ADDR_OUT_OVR: n.override = val;
                `MSR_ADDR_AO_ONE: n.ao_one = val;
                `MSR_ADDR_AO_TWO: n.ao_two = val;
                default: n.pulse = val;
              endcase
            end
          end else begin
            exc = `MSR_EXC_FUNC;
          end
          if (exc != 8'h00) begin
            // exception answer: function with top bit set, then the code
            n.tx_buf[1] = func | `MSR_EXC_FLAG;
            n.tx_buf[2] = exc;
            n.tx_len = `MSR_EXC_LEN;
          end
        end
      end

      // hand bytes to the character transmitter, check sum last
      MSR_TX: begin
        if (!r.tx_valid) begin
          if (r.tx_idx < r.tx_len) begin
            tb = r.tx_buf[r.tx_idx[3:0]];
          end else if (r.tx_idx == r.tx_len) begin
            tb = r.tx_crc[7:0];
          end else begin
            tb = r.tx_crc[15:8];
          end
          n.tx_data = tb;
          n.tx_valid = 1'b1;
        end else if (tx_ready) begin
          n.tx_valid = 1'b0;
          n.tx_idx = r.tx_idx + 5'h01;
          if (r.tx_idx < r.tx_len) begin
            n.tx_crc = crc_step(r.tx_crc, r.tx_data);
          end
          if (r.tx_idx == r.tx_len + 5'h01) begin
            // answer done: keep the line quiet before listening again
            n.state = MSR_GAP;
            n.gap_long = 1'b1;
            n.gap_cnt = 24'h000000;
          end
        end
      end
    endcase

    // terminal and analog outputs, overridden only when selected
    n.transistor_output = (transistor_output_func == `MSR_OUT_FUNC_COMM) ?
      r.override[`MSR_BIT_TRANSISTOR] : drive_transistor;
    n.relay_one_output = (relay_one_func == `MSR_OUT_FUNC_COMM) ?
      r.override[`MSR_BIT_RELAY] : drive_relay_one;
    n.freq_pulse_terminal = (freq_pulse_func == `MSR_OUT_FUNC_COMM) ?
      r.override[`MSR_BIT_FREQ] : drive_freq_pulse;
    n.analog_out_one = (analog_out_one_func == `MSR_AO_FUNC_COMM) ?
      clamp_level(r.ao_one) : drive_analog_one;
    n.analog_out_two = (analog_out_two_func == `MSR_AO_FUNC_COMM) ?
      clamp_level(r.ao_two) : drive_analog_two;
    n.pulse_output = (pulse_output_func == `MSR_AO_FUNC_COMM) ?
      clamp_level(r.pulse) : drive_pulse;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      r <= '0;
      r.run_state <= `MSR_STATE_STOP;
      r.rx_crc <= `MSR_CRC_PRESET;
      r.tx_crc <= `MSR_CRC_PRESET;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_data = r.tx_data;
  assign tx_valid = r.tx_valid;
  assign transistor_output = r.transistor_output;
  assign relay_one_output = r.relay_one_output;
  assign freq_pulse_terminal = r.freq_pulse_terminal;
  assign analog_out_one = r.analog_out_one;
  assign analog_out_two = r.analog_out_two;
  assign pulse_output = r.pulse_output;
  assign run_command = r.cmd_code;
  assign run_command_strobe = r.cmd_strobe;
  assign run_state = r.run_state;

endmodule // msr_bank

// ### common/msr_defs.svh
// constants of the serial special-register bank: addresses, codes, field positions and timing
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define MSR_ADDR_RUN_FREQ 16'h1001
`define MSR_ADDR_DC_BUS 16'h1002
`define MSR_ADDR_OUT_VOLT 16'h1003
`define MSR_ADDR_OUT_CURR 16'h1004
`define MSR_ADDR_OUT_POWER 16'h1005
`define MSR_ADDR_OUT_TORQUE 16'h1006
`define MSR_ADDR_RUN_SPEED 16'h1007
`define MSR_ADDR_IN_TERM 16'h1008
`define MSR_ADDR_OUT_TERM 16'h1009
`define MSR_ADDR_AIN_ONE 16'h100a
`define MSR_ADDR_AIN_TWO 16'h100b
`define MSR_ADDR_AIN_THREE 16'h100c
`define MSR_ADDR_LOAD_SPEED 16'h100f
`define MSR_ADDR_FB_FREQ 16'h1013
`define MSR_ADDR_ENC_FREQ 16'h101e
`define MSR_ADDR_RUN_CMD 16'h2000
`define MSR_ADDR_OUT_OVR 16'h2001
`define MSR_ADDR_AO_ONE 16'h2002
`define MSR_ADDR_AO_TWO 16'h2003
`define MSR_ADDR_PULSE 16'h2004
`define MSR_ADDR_RUN_STATE 16'h3000
`define MSR_ADDR_FAULT 16'h8000

// ----------------------------------------------------------------
// frame codes
// ----------------------------------------------------------------
`define MSR_FC_READ 8'h03
`define MSR_FC_WRITE_RAM 8'h05
`define MSR_FC_WRITE 8'h06
`define MSR_EXC_FLAG 8'h80
`define MSR_EXC_FUNC 8'h02
`define MSR_EXC_CRC 8'h03
`define MSR_EXC_ADDR 8'h04
`define MSR_EXC_RANGE 8'h05
`define MSR_EXC_RDONLY 8'h06
`define MSR_REQ_LEN 4'h8
`define MSR_MAX_READ 16'h0004
`define MSR_ECHO_LEN 5'h06
`define MSR_EXC_LEN 5'h03
`define MSR_READ_HDR 5'h03

// ----------------------------------------------------------------
// check sum
// ----------------------------------------------------------------
`define MSR_CRC_PRESET 16'hffff
`define MSR_CRC_POLY 16'ha001

// ----------------------------------------------------------------
// selections, codes and fields
// ----------------------------------------------------------------
`define MSR_SRC_COMM 4'h2
`define MSR_OUT_FUNC_COMM 5'h14
`define MSR_AO_FUNC_COMM 5'h0c
`define MSR_FULL_SCALE 15'h7fff
`define MSR_BIT_TRANSISTOR 0
`define MSR_BIT_RELAY 2
`define MSR_BIT_FREQ 4
`define MSR_STATE_FWD 16'h0001
`define MSR_STATE_REV 16'h0002
`define MSR_STATE_STOP 16'h0003
`define MSR_CMD_FWD 3'h1
`define MSR_CMD_REV 3'h2
`define MSR_CMD_JOG_FWD 3'h3
`define MSR_CMD_JOG_REV 3'h4
`define MSR_CMD_COAST 3'h5
`define MSR_CMD_DECEL 3'h6
`define MSR_CMD_FAULT_RST 3'h7
`define MSR_CMD_MAX 16'h0007

// ----------------------------------------------------------------
// timing: one character of 11 bits at 9600 baud, clock period 5 ns
// ----------------------------------------------------------------
`define MSR_CHAR_TIME_NS 1145834
`define MSR_CLK_NS 5
// 3.5 character times, rounded up to whole cycles
`define MSR_SILENCE_CYCLES ((`MSR_CHAR_TIME_NS * 35 + `MSR_CLK_NS * 10 - 1) / (`MSR_CLK_NS * 10))
// one character time, rounded up
`define MSR_CHAR_CYCLES ((`MSR_CHAR_TIME_NS + `MSR_CLK_NS - 1) / `MSR_CLK_NS)

`endif

// ### common/msr_pkg.sv
// types of the serial special-register bank
package msr_pkg;

  // ----------------------------------------------------------------
  // frame engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSR_GAP  = 2'b00,
    MSR_RX   = 2'b01,
    MSR_EXEC = 2'b10,
    MSR_TX   = 2'b11
  } msr_state_e;

  // ----------------------------------------------------------------
  // whole state of the bank
  // ----------------------------------------------------------------
  typedef struct packed {
    msr_state_e state;
    logic gap_long;
    logic [23:0] gap_cnt;
    logic [3:0] rx_cnt;
    logic rx_over;
    logic [15:0] rx_crc;
    logic [7:0][7:0] rx_buf;
    logic [15:0][7:0] tx_buf;
    logic [4:0] tx_len;
    logic [4:0] tx_idx;
    logic [15:0] tx_crc;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [15:0] override;
    logic [15:0] ao_one;
    logic [15:0] ao_two;
    logic [15:0] pulse;
    logic [15:0] run_state;
    logic [2:0] cmd_code;
    logic cmd_strobe;
    logic transistor_output;
    logic relay_one_output;
    logic freq_pulse_terminal;
    logic [14:0] analog_out_one;
    logic [14:0] analog_out_two;
    logic [14:0] pulse_output;
  } msr_state_s;

endpackage

// ### verif/msr_bank_chk.sv
// port assertions of the serial special-register bank
`timescale 1ns/1ps
module msr_bank_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [3:0] run_command_source,
  input wire logic [2:0] run_command,
  input wire logic run_command_strobe,
  input wire logic [15:0] run_state,
  input wire logic [4:0] transistor_output_func,
  input wire logic drive_transistor,
  input wire logic transistor_output
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // assertions; $past(rst_b, 3) waits out the reset synchroniser
  // ----------------------------------------------------------------
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte not held");
  a_tx_release: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("tx valid not released");
  a_strobe_pulse: assert property (run_command_strobe |=> !run_command_strobe)
    else $error("strobe too long");
  a_strobe_source: assert property (run_command_strobe |-> $past(run_command_source) == 4'h2)
    else $error("command off link");
  a_cmd_range: assert property (run_command_strobe |-> run_command != 3'h0)
    else $error("bad command code");
  a_state_fwd: assert property (run_command_strobe && run_command inside {3'h1, 3'h3} |->
    ##[0:1] run_state == 16'h0001)
    else $error("not forward");
  a_state_stop: assert property (run_command_strobe && run_command inside {3'h5, 3'h6} |->
    ##[0:1] run_state == 16'h0003)
    else $error("not stopped");
  a_state_legal: assert property (run_state inside {16'h0001, 16'h0002, 16'h0003})
    else $error("bad run state");
  a_trans_mux: assert property ($past(rst_b, 3) && $past(transistor_output_func) != 5'h14 |->
    transistor_output == $past(drive_transistor))
    else $error("bad transistor mux");
  // main scenarios reached
  c_command: cover property (run_command_strobe);
  c_handoff: cover property (tx_valid && tx_ready);
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule // msr_bank_chk

bind msr_bank msr_bank_chk u_msr_bank_chk (.*);

// ### verif/msr_master_model.sv
// link master model: sends request frames and collects answer bytes
`timescale 1ns/1ps
module msr_master_model #(
  parameter logic [7:0] STATION = 8'h11
) (
  input wire logic ref_clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] resp [$]; // answer bytes of the last request
  bit slow = 1'b0; // stall the transmitter every other cycle
  initial {rx_data, rx_valid, tx_ready} = 10'h000;
  // ready toggles when slow, otherwise stands high
  always @(negedge ref_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // take each byte handed over
  always @(posedge ref_clk) if (tx_valid && tx_ready) resp.push_back(tx_data);
  // ----------------------------------------------------------------
  // check sum over data bytes only
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc(input logic [7:0] q [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    end
    return c;
  endfunction
  // one 8-byte request; bad spoils the check sum
  task automatic send(input logic [7:0] fc, input logic [15:0] ad, dt, input bit bad);
    logic [7:0] q [$];
    logic [15:0] c;
    q = {STATION, fc, ad[15:8], ad[7:0], dt[15:8], dt[7:0]};
    c = crc(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    resp.delete();
    foreach (q[i]) begin
      @(negedge ref_clk);
      rx_data <= q[i];
      rx_valid <= 1'b1;
      @(negedge ref_clk);
      rx_valid <= 1'b0;
      rx_data <= ~q[i]; // no stale value between characters
    end
  endtask
endmodule // msr_master_model

// ### verif/msr_bank_tb_top.sv
// self-checking bench of the serial special-register bank
`timescale 1ns/1ps
module msr_bank_tb_top;
  logic ref_clk, rst_b, rx_valid, tx_valid, tx_ready, fault_active, run_command_strobe;
  logic drive_transistor, drive_relay_one, drive_freq_pulse, transistor_output, relay_one_output, freq_pulse_terminal;
  logic [7:0] rx_data, tx_data;
  logic [2:0] run_command;
  logic [3:0] run_command_source;
  logic [4:0] transistor_output_func, relay_one_func, freq_pulse_func, analog_out_one_func, analog_out_two_func;
  logic [4:0] pulse_output_func;
  logic [14:0] drv [3]; // drive's own analog and pulse levels
  logic [14:0] aout [3]; // analog one, two and pulse outputs
  logic [15:0] mon [14]; // monitoring words in address order
  logic [15:0] fault_code, run_state, st;
  int mismatches = 0, num_checks = 0, strobes = 0;
  // monitoring addresses, same order as mon
  localparam logic [15:0] RD [14] = '{16'h1001, 16'h1002, 16'h1003, 16'h1004, 16'h1005, 16'h1006, 16'h1007,
    16'h1008, 16'h100a, 16'h100b, 16'h100c, 16'h100f, 16'h1013, 16'h101e};
  // level rows: address, written value, expected output
  localparam logic [15:0] WR [4][3] = '{'{16'h2002, 16'h1234, 16'h1234}, '{16'h2003, 16'h7fff, 16'h7fff},
    '{16'h2004, 16'h4321, 16'h4321}, '{16'h2002, 16'h8000, 16'h7fff}};
  // ----------------------------------------------------------------
  // design and master
  // ----------------------------------------------------------------
  msr_bank #(.SILENCE_CYCLES(24'h14), .TX_GAP_CYCLES(24'h1e)) u_msr_bank (
    .*, .slave_address(8'h11),
    .mon_running_frequency(mon[0]), .mon_dc_bus_voltage(mon[1]), .mon_output_voltage(mon[2]),
    .mon_output_current(mon[3]), .mon_output_power(mon[4]), .mon_output_torque(mon[5]),
    .mon_running_speed(mon[6]), .mon_input_terminal_state(mon[7]), .mon_analog_in_one(mon[8]),
    .mon_analog_in_two(mon[9]), .mon_analog_in_three(mon[10]), .mon_load_speed(mon[11]),
    .mon_feedback_frequency(mon[12]), .mon_encoder_frequency(mon[13]),
    .drive_analog_one(drv[0]), .drive_analog_two(drv[1]), .drive_pulse(drv[2]),
    .analog_out_one(aout[0]), .analog_out_two(aout[1]), .pulse_output(aout[2]));
  msr_master_model #(.STATION(8'h11)) u_msr_master_model (.*);
  always #2.5 ref_clk = ~ref_clk;
  // counts accepted commands
  always @(posedge ref_clk) if (run_command_strobe === 1'b1) strobes++;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, its answer of n bytes, then a quiet gap
  task automatic xfer(input logic [7:0] fc, input logic [15:0] ad, dt, input bit bad, input int n);
    int w = 0;
    u_msr_master_model.send(fc, ad, dt, bad);
    while (u_msr_master_model.resp.size() < n && w < 1000) begin
      @(negedge ref_clk);
      w++;
    end
    repeat (80) @(negedge ref_clk);
    check(16'(u_msr_master_model.resp.size()), 16'(n));
    check(u_msr_master_model.crc(u_msr_master_model.resp), 16'h0000);
  endtask
  function automatic logic [15:0] word(input int i);
    return {u_msr_master_model.resp[i], u_msr_master_model.resp[i + 1]};
  endfunction
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog: the run needs about 4800 cycles
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    fault_active = 1'b0;
    fault_code = 16'h002a;
    run_command_source = 4'h2;
    {transistor_output_func, relay_one_func, freq_pulse_func} = {3{5'h14}};
    {analog_out_one_func, analog_out_two_func, pulse_output_func} = {3{5'h0c}};
    {drive_transistor, drive_relay_one, drive_freq_pulse} = 3'h0;
    drv = '{3{15'h0555}};
    foreach (mon[i]) mon[i] = 16'(16'h1100 + i * 16'h0101);
    repeat (16) @(negedge ref_clk);
    rst_b <= 1'b1;
    repeat (40) @(negedge ref_clk);
    foreach (RD[i]) begin
      xfer(8'h03, RD[i], 16'h0001, 1'b0, 7);
      check(word(3), mon[i]);
    end
    u_msr_master_model.slow = 1'b1;
    foreach (WR[i]) begin
      xfer(8'h06, WR[i][0], WR[i][1], 1'b0, 8);
      check({1'b0, aout[i % 3]}, WR[i][2]);
    end
    u_msr_master_model.slow = 1'b0;
    // run state, fault code clear and set
    xfer(8'h03, 16'h3000, 16'h0001, 1'b0, 7);
    check(word(3), 16'h0003);
    xfer(8'h03, 16'h8000, 16'h0001, 1'b0, 7);
    check(word(3), 16'h0000);
    fault_active = 1'b1;
    xfer(8'h03, 16'h8000, 16'h0001, 1'b0, 7);
    check(word(3), fault_code);
    // override, readback, reserved bits, drive mux
    xfer(8'h06, 16'h2001, 16'h0015, 1'b0, 8);
    check(16'({transistor_output, relay_one_output, freq_pulse_terminal}), 16'h0007);
    xfer(8'h03, 16'h1009, 16'h0001, 1'b0, 7);
    check(word(3), 16'h0015);
    {transistor_output_func, relay_one_func} = {2{5'h13}};
    {drive_transistor, drive_relay_one} = 2'h3;
    xfer(8'h06, 16'h2001, 16'h000a, 1'b0, 8);
    check(16'({transistor_output, relay_one_output, freq_pulse_terminal}), 16'h0006);
    // every command code, one strobe each
    st = 16'h0003;
    for (int c = 1; c < 8; c++) begin
      xfer(c[0] ? 8'h05 : 8'h06, 16'h2000, 16'(c), 1'b0, 8);
      st = (c == 7) ? st : 16'(c < 5 ? 2 - c % 2 : 3);
      check(16'(run_command), 16'(c));
      check(run_state, st);
      check(16'(strobes), 16'(c));
    end
    // command zero refused
    xfer(8'h06, 16'h2000, 16'h0000, 1'b0, 5);
    check(word(1), 16'h8605);
    check(16'(strobes), 16'h0007);
    // source not the link
    run_command_source = 4'h1;
    xfer(8'h06, 16'h2000, 16'h0002, 1'b0, 8);
    check(run_state, st);
    check(16'(strobes), 16'h0007);
    // bad check sum, write to a read-only word
    xfer(8'h03, 16'h1001, 16'h0001, 1'b1, 5);
    check(word(1), 16'h8303);
    xfer(8'h06, 16'h1001, 16'h0001, 1'b0, 5);
    check(word(1), 16'h8606);
    stop_test();
  end
endmodule // msr_bank_tb_top
